// ==== hw/rbk_rtc.v ====
// calendar timer with alarm, shift, calibration, tamper, timestamp and backup words
//
// Our own choices: the register addresses and the address-and-strobe port.
`include "rbk_regs.vh"
module rbk_rtc (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire [7:0] addr_in,
  input wire [31:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output reg [31:0] rd_data_out,
  input wire xtal_tick_in,
  input wire resonator_tick_in,
  input wire lprc_tick_in,
  input wire fast_external_oscillator_in,
  input wire ref_clk_in,
  input wire tamper_input_one_in,
  input wire tamper_input_two_in,
  input wire timestamp_input_in,
  output reg alarm_wake_out,
  output reg tamper_wake_out,
  output reg stamp_wake_out
);
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function is_leap;
    input [7:0] y;
    begin
      if (y[4] == 1'b0)
        is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      else
        is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
  endfunction

  function [5:0] last_day;
    input [4:0] m;
    input [7:0] y;
    begin
      case (m)
        5'h02: last_day = is_leap(y) ? 6'h29 : 6'h28;
        5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
        default: last_day = 6'h31;
      endcase
    end
  endfunction

  wire wr_time = wr_en_in && (addr_in == `RBK_OFS_TIME);
  wire wr_date = wr_en_in && (addr_in == `RBK_OFS_DATE);
  wire wr_stat = wr_en_in && (addr_in == `RBK_OFS_STAT);
  wire wr_shift = wr_en_in && (addr_in == `RBK_OFS_SHIFT);
  wire bkp_hit = (addr_in >= `RBK_OFS_BKP0) && (addr_in <= `RBK_BKP_LAST) &&
                 (addr_in[1:0] == 2'h0);
  wire [7:0] bkp_ofs = addr_in - `RBK_OFS_BKP0;
  wire [2:0] bkp_idx = bkp_ofs[4:2];

  // full-width copies of the reset words so that fields can be part-selected
  localparam [31:0] TIME_RST = `RBK_TIME_RST, DATE_RST = `RBK_DATE_RST;
  localparam [31:0] PRESC_RST = `RBK_PRESC_RST;
  reg [31:0] ctrl_q;
  reg [31:0] presc_q;
  reg [31:0] cal_q;
  reg [31:0] alarm_q;
  reg [31:0] bkp_mem [0:4];

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= `RBK_CTRL_RST;
      presc_q <= `RBK_PRESC_RST;
      cal_q <= `RBK_CAL_RST;
      alarm_q <= `RBK_ALARM_RST;
    end else if (wr_en_in) begin
      if (addr_in == `RBK_OFS_CTRL)
        ctrl_q <= wr_data_in;
      if (addr_in == `RBK_OFS_PRESC)
        presc_q <= wr_data_in & 32'h007f7fff;
      if (addr_in == `RBK_OFS_CAL)
        cal_q <= wr_data_in & 32'h000081ff;
      if (addr_in == `RBK_OFS_ALARM)
        alarm_q <= wr_data_in;
    end
  end

  // backup words have no reset branch at all
  always @(posedge mclk_in) begin
    if (wr_en_in && bkp_hit)
      bkp_mem[bkp_idx] <= wr_data_in;
  end

  // clock source selection
  reg [4:0] fdiv_q;
  reg src_tick;
  wire fast_tick = fast_external_oscillator_in && (fdiv_q == `RBK_FAST_DIV_LAST);
  always @(posedge mclk_in) begin
    if (sys_rst_in)
      fdiv_q <= 5'h00;
    else if (fast_external_oscillator_in)
      fdiv_q <= fdiv_q + 5'h01;
  end
  always @* begin
    case (ctrl_q[`RBK_C_CLKSEL])
      2'h0: src_tick = xtal_tick_in;
      2'h1: src_tick = resonator_tick_in;
      2'h2: src_tick = lprc_tick_in;
      default: src_tick = fast_tick;
    endcase
  end

  // calibration window of 2^20 source ticks
  reg [19:0] win_q;
  reg extra_q;
  wire skip = (win_q[10:0] == 11'h000) && (win_q[19:11] < cal_q[8:0]);
  wire add_slot = cal_q[15] && (win_q[10:0] == `RBK_CAL_ADD_PHASE);
  wire cal_tick = (src_tick && !skip) || extra_q;
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      win_q <= 20'h00000;
      extra_q <= 1'b0;
    end else begin
      extra_q <= src_tick && add_slot;
      if (src_tick)
        win_q <= win_q + 20'h00001;
    end
  end

  // prescalers, shift and reference clock
  reg [6:0] acnt_q;
  reg [14:0] ss_q;
  reg sh_pend_q;
  reg sh_add1_q;
  reg [14:0] sh_sub_q;
  reg ref_q;
  reg [5:0] rcnt_q;
  reg sec_tick_q;
  wire ref_en = ctrl_q[`RBK_C_REF_EN];
  wire ck_spre = cal_tick && (acnt_q == 7'h00);
  wire ref_rise = ref_clk_in && !ref_q;
  wire [5:0] ref_last = ctrl_q[`RBK_C_REF60] ? `RBK_REF60_CNT : `RBK_REF50_CNT;
  wire ref_sec = ref_en && ref_rise && (rcnt_q + 6'h01 == ref_last);
  wire [15:0] ss_sum = {1'b0, ss_q} + {1'b0, sh_sub_q};
  wire [15:0] ss_wrap = ss_sum - {1'b0, presc_q[14:0]} - 16'h0001;
  wire ss_over = ss_sum > {1'b0, presc_q[14:0]};
  wire sh_apply = sh_pend_q && ck_spre;

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      acnt_q <= PRESC_RST[22:16];
      ss_q <= PRESC_RST[14:0];
      sh_pend_q <= 1'b0;
      sh_add1_q <= 1'b0;
      sh_sub_q <= 15'h0000;
      ref_q <= 1'b0;
      rcnt_q <= 6'h00;
      sec_tick_q <= 1'b0;
    end else begin
      ref_q <= ref_clk_in;
      sec_tick_q <= 1'b0;
      if (wr_shift && !sh_pend_q) begin
        sh_pend_q <= 1'b1;
        sh_add1_q <= wr_data_in[31];
        sh_sub_q <= wr_data_in[14:0];
      end
      if (ref_en && ref_rise)
        rcnt_q <= ref_sec ? 6'h00 : rcnt_q + 6'h01;
      if (ref_sec) begin
        acnt_q <= presc_q[22:16];
        ss_q <= presc_q[14:0];
        sec_tick_q <= 1'b1;
      end else if (wr_time) begin
        acnt_q <= presc_q[22:16];
        ss_q <= presc_q[14:0];
      end else if (cal_tick) begin
        acnt_q <= (acnt_q == 7'h00) ? presc_q[22:16] : acnt_q - 7'h01;
        if (sh_apply) begin
          ss_q <= ss_over ? ss_wrap[14:0] : ss_sum[14:0];
          sh_pend_q <= 1'b0;
          sec_tick_q <= sh_add1_q;
        end else if (ck_spre) begin
          ss_q <= (ss_q == 15'h0000) ? presc_q[14:0] : ss_q - 15'h0001;
          if (ss_q == 15'h0000 && !ref_en)
            sec_tick_q <= 1'b1;
        end
      end
    end
  end

  // calendar
  reg [6:0] sec_q;
  reg [6:0] min_q;
  reg [5:0] hour_q;
  reg pm_q;
  reg [2:0] wday_q;
  reg [5:0] date_q;
  reg [4:0] mon_q;
  reg [7:0] year_q;
  reg [5:0] hour_nx;
  reg pm_nx;
  reg hour_day;
  wire fmt12 = ctrl_q[`RBK_C_FMT12];
  wire [7:0] sec_i = bcd_inc({1'b0, sec_q});
  wire [7:0] min_i = bcd_inc({1'b0, min_q});
  wire [7:0] hour_i = bcd_inc({2'b00, hour_q});
  wire [7:0] date_i = bcd_inc({2'b00, date_q});
  wire [7:0] mon_i = bcd_inc({3'b000, mon_q});
  wire sec_wrap = sec_q == 7'h59;
  wire min_wrap = min_q == 7'h59;
  wire day_tick = sec_tick_q && sec_wrap && min_wrap && hour_day;

  always @* begin
    hour_nx = hour_i[5:0];
    pm_nx = pm_q;
    hour_day = 1'b0;
    if (fmt12) begin
      if (hour_q == 6'h12) begin
        hour_nx = 6'h01;
      end else if (hour_q == 6'h11) begin
        pm_nx = ~pm_q;
        hour_day = pm_q;
      end
    end else if (hour_q == 6'h23) begin
      hour_nx = 6'h00;
      hour_day = 1'b1;
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sec_q <= TIME_RST[6:0];
      min_q <= TIME_RST[14:8];
      hour_q <= TIME_RST[21:16];
      pm_q <= 1'b0;
    end else if (wr_time) begin
      sec_q <= wr_data_in[6:0];
      min_q <= wr_data_in[14:8];
      hour_q <= wr_data_in[21:16];
      pm_q <= wr_data_in[22];
    end else if (sec_tick_q) begin
      sec_q <= sec_wrap ? 7'h00 : sec_i[6:0];
      if (sec_wrap) begin
        min_q <= min_wrap ? 7'h00 : min_i[6:0];
        if (min_wrap) begin
          hour_q <= hour_nx;
          pm_q <= pm_nx;
        end
      end
    end
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      date_q <= DATE_RST[5:0];
      mon_q <= DATE_RST[12:8];
      wday_q <= DATE_RST[15:13];
      year_q <= DATE_RST[23:16];
    end else if (wr_date) begin
      date_q <= wr_data_in[5:0];
      mon_q <= wr_data_in[12:8];
      wday_q <= wr_data_in[15:13];
      year_q <= wr_data_in[23:16];
    end else if (day_tick) begin
      wday_q <= (wday_q == 3'h7) ? 3'h1 : wday_q + 3'h1;
      if (date_q == last_day(mon_q, year_q)) begin
        date_q <= 6'h01;
        if (mon_q == 5'h12) begin
          mon_q <= 5'h01;
          year_q <= (year_q == 8'h99) ? 8'h00 : bcd_inc(year_q);
        end else begin
          mon_q <= mon_i[4:0];
        end
      end else begin
        date_q <= date_i[5:0];
      end
    end
  end

  wire [31:0] time_w = {9'h000, pm_q, hour_q, 1'b0, min_q, 1'b0, sec_q};
  wire [31:0] date_w = {8'h00, year_q, wday_q, mon_q, 2'b00, date_q};

  // alarm: a set mask bit ignores that field
  reg sec_tick_d;
  wire alm_match = (alarm_q[7] || alarm_q[6:0] == sec_q) &&
                   (alarm_q[15] || alarm_q[14:8] == min_q) &&
                   (alarm_q[23] || (alarm_q[21:16] == hour_q &&
                    (!fmt12 || alarm_q[22] == pm_q))) &&
                   (alarm_q[31] || alarm_q[29:24] == date_q);
  wire alarm_set = sec_tick_d && ctrl_q[`RBK_C_ALRM_EN] && alm_match;

  // tamper filters and timestamp source
  wire [1:0] tamp_pin = {tamper_input_two_in, tamper_input_one_in};
  wire [1:0] tamp_evt;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tamp
      rbk_tamp_filt u_filt (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .sample_en_in(cal_tick),
        .enable_in(ctrl_q[12 + gi]),
        .pin_in(tamp_pin[gi]),
        .active_high_in(ctrl_q[14 + gi]),
        .filt_in(ctrl_q[`RBK_C_FILT]),
        .event_out(tamp_evt[gi])
      );
    end
  endgenerate

  reg ts_pin_q;
  wire ts_edge = ctrl_q[`RBK_C_TS_FALL] ? (ts_pin_q && !timestamp_input_in) :
                 (!ts_pin_q && timestamp_input_in);
  wire ts_set = (ctrl_q[`RBK_C_TS_EN] && ts_edge) ||
                (ctrl_q[`RBK_C_TAMPTS] && (tamp_evt != 2'b00));

  reg [31:0] ts_time_q;
  reg [31:0] ts_date_q;
  reg [14:0] ts_sub_q;
  reg [4:0] flag_q;
  wire [4:0] flag_set = {ts_set && flag_q[`RBK_S_TS], ts_set, tamp_evt, alarm_set};
  wire [4:0] flag_clr = wr_stat ? wr_data_in[4:0] : 5'h00;

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sec_tick_d <= 1'b0;
      ts_pin_q <= 1'b0;
      ts_time_q <= 32'h00000000;
      ts_date_q <= 32'h00000000;
      ts_sub_q <= 15'h0000;
      flag_q <= 5'h00;
      alarm_wake_out <= 1'b0;
      tamper_wake_out <= 1'b0;
      stamp_wake_out <= 1'b0;
    end else begin
      sec_tick_d <= sec_tick_q;
      ts_pin_q <= timestamp_input_in;
      if (ts_set) begin
        ts_time_q <= time_w;
        ts_date_q <= date_w;
        ts_sub_q <= ss_q;
      end
      flag_q <= (flag_q & ~flag_clr) | flag_set;
      alarm_wake_out <= flag_q[`RBK_S_ALARM] && ctrl_q[`RBK_C_ALRM_WK];
      tamper_wake_out <= (flag_q[`RBK_S_TAMP1] || flag_q[`RBK_S_TAMP2]) &&
                         ctrl_q[`RBK_C_TAMP_WK];
      stamp_wake_out <= flag_q[`RBK_S_TS] && ctrl_q[`RBK_C_TS_WK];
    end
  end

  // read port: data stand only in the cycle after the strobe
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (addr_in)
      `RBK_OFS_TIME: rd_mux = time_w;
      `RBK_OFS_DATE: rd_mux = date_w;
      `RBK_OFS_CTRL: rd_mux = ctrl_q;
      `RBK_OFS_STAT: rd_mux = {26'h0000000, sh_pend_q, flag_q};
      `RBK_OFS_PRESC: rd_mux = presc_q;
      `RBK_OFS_SHIFT: rd_mux = {sh_add1_q, 16'h0000, sh_sub_q};
      `RBK_OFS_CAL: rd_mux = cal_q;
      `RBK_OFS_ALARM: rd_mux = alarm_q;
      `RBK_OFS_SUBSEC: rd_mux = {17'h00000, ss_q};
      `RBK_OFS_TSTIME: rd_mux = ts_time_q;
      `RBK_OFS_TSDATE: rd_mux = ts_date_q;
      `RBK_OFS_TSSUB: rd_mux = {17'h00000, ts_sub_q};
      default: rd_mux = bkp_hit ? bkp_mem[bkp_idx] : 32'h00000000;
    endcase
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in)
      rd_data_out <= 32'h00000000;
    else
      rd_data_out <= rd_en_in ? rd_mux : 32'h00000000;
  end
endmodule

// ==== hw/rbk_regs.vh ====
// register offsets, field positions and reset values of the calendar timer
`ifndef RBK_REGS_VH
`define RBK_REGS_VH
`define RBK_OFS_TIME 8'h00
`define RBK_OFS_DATE 8'h04
`define RBK_OFS_CTRL 8'h08
`define RBK_OFS_STAT 8'h0c
`define RBK_OFS_PRESC 8'h10
`define RBK_OFS_SHIFT 8'h14
`define RBK_OFS_CAL 8'h18
`define RBK_OFS_ALARM 8'h1c
`define RBK_OFS_SUBSEC 8'h20
`define RBK_OFS_TSTIME 8'h24
`define RBK_OFS_TSDATE 8'h28
`define RBK_OFS_TSSUB 8'h2c
`define RBK_OFS_BKP0 8'h50
`define RBK_BKP_LAST 8'h60
`define RBK_TIME_RST 32'h00000000
`define RBK_DATE_RST 32'h00002101
`define RBK_CTRL_RST 32'h00000000
`define RBK_PRESC_RST 32'h007f00ff
`define RBK_CAL_RST 32'h00000000
`define RBK_ALARM_RST 32'h80808000
`define RBK_C_FMT12 0
`define RBK_C_ALRM_EN 1
`define RBK_C_ALRM_WK 2
`define RBK_C_TS_EN 3
`define RBK_C_TS_FALL 4
`define RBK_C_TAMP_WK 5
`define RBK_C_TS_WK 6
`define RBK_C_REF_EN 7
`define RBK_C_REF60 8
`define RBK_C_CLKSEL 10:9
`define RBK_C_TAMPTS 11
`define RBK_C_TAMP_EN 13:12
`define RBK_C_TAMP_HI 15:14
`define RBK_C_FILT 17:16
`define RBK_S_ALARM 0
`define RBK_S_TAMP1 1
`define RBK_S_TAMP2 2
`define RBK_S_TS 3
`define RBK_S_TSOV 4
`define RBK_S_SHPEND 5
`define RBK_FAST_DIV_LAST 5'd31
`define RBK_REF50_CNT 6'd50
`define RBK_REF60_CNT 6'd60
`define RBK_CAL_ADD_PHASE 11'h400
`endif

// ==== hw/rbk_tamp_filt.v ====
// one tamper input: edge detect or sampled level filter
module rbk_tamp_filt (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire sample_en_in,
  input wire enable_in,
  input wire pin_in,
  input wire active_high_in,
  input wire [1:0] filt_in,
  output reg event_out
);
  reg act_q;
  reg [3:0] cnt_q;
  reg fired_q;
  wire act = active_high_in ? pin_in : ~pin_in;
  wire [3:0] need = 4'h1 << filt_in;

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      act_q <= 1'b0;
      cnt_q <= 4'h0;
      fired_q <= 1'b0;
      event_out <= 1'b0;
    end else begin
      act_q <= act;
      event_out <= 1'b0;
      if (!enable_in) begin
        cnt_q <= 4'h0;
        fired_q <= 1'b0;
      end else if (filt_in == 2'h0) begin
        event_out <= act & ~act_q;
      end else if (sample_en_in) begin
        if (act) begin
          if (cnt_q != need)
            cnt_q <= cnt_q + 4'h1;
          if ((cnt_q + 4'h1 == need) && !fired_q) begin
            event_out <= 1'b1;
            fired_q <= 1'b1;
          end
        end else begin
          cnt_q <= 4'h0;
          fired_q <= 1'b0;
        end
      end
    end
  end
endmodule

// ==== tb/rbk_clk_model.sv ====
// partner model: slow and fast clock sources and reference clock, emitted in bursts on request
module rbk_clk_model (
  input wire logic mclk_in,
  input wire logic go_in,
  input wire logic [2:0] which_in,
  input wire logic [11:0] cnt_in,
  output logic busy_out,
  output logic [4:0] tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // per line spacing in cycles: crystal, resonator, rc, fast, reference
  int sp [5] = '{2, 3, 1, 1, 4};
  int left [5] = '{0, 0, 0, 0, 0};
  int cyc = 0;
  int n;
  initial tick_out = 5'h0;
  assign busy_out = (left[0] + left[1] + left[2] + left[3] + left[4]) != 0;
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 5; i++) begin
      tick_out[i] <= 1'h0;
      if (go_in) begin
        // unselected sources get 3 more ticks but stay idle for a reference burst, so a wrong source choice shows
        n = (which_in == 3'h4) ? ((i == 4) ? cnt_in : 0) :
            ((i == 4) ? 0 : (i == which_in) ? cnt_in : cnt_in + 3);
        left[i] <= (i == 3) ? n * 32 : n;
      end else if (left[i] > 0 && cyc % sp[i] == 0) begin
        tick_out[i] <= 1'h1;
        left[i] <= left[i] - 1;
      end
    end
  end
endmodule

// ==== tb/rbk_rtc_asserts.sv ====
// port checker for the calendar timer
module rbk_rtc_asserts (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire [7:0] addr_in,
  input wire [31:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [31:0] rd_data_out,
  input wire alarm_wake_out,
  input wire tamper_wake_out,
  input wire stamp_wake_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  wire cfg_wr = wr_en_in && (addr_in == 8'h0c || addr_in == 8'h08);
  property p_hold(w);
    w && !cfg_wr && !$past(cfg_wr) |=> w;
  endproperty
  AST_RD_IDLE:
    assert property (!rd_en_in |=> rd_data_out == 32'h0) else $error("stray read data");
  AST_RST_QUIET:
    assert property ($fell(sys_rst_in) |-> !alarm_wake_out && !tamper_wake_out
      && !stamp_wake_out) else $error("wake after reset");
  AST_UNMAPPED:
    assert property (rd_en_in && addr_in == 8'h40 |=> rd_data_out == 32'h0)
      else $error("unmapped read not zero");
  AST_BKP_RW:
    assert property (wr_en_in && addr_in == 8'h50 ##2 rd_en_in && addr_in == 8'h50
      |=> rd_data_out == $past(wr_data_in, 3)) else $error("backup word lost");
  AST_TIME_BCD:
    assert property (rd_en_in && addr_in == 8'h00 |=> rd_data_out[3:0] <= 4'h9
      && rd_data_out[6:4] <= 3'h5 && rd_data_out[11:8] <= 4'h9 && rd_data_out[14:12] <= 3'h5)
      else $error("time not bcd");
  AST_DATE_BCD:
    assert property (rd_en_in && addr_in == 8'h04 |=> rd_data_out[3:0] <= 4'h9
      && rd_data_out[5:0] != 6'h0 && rd_data_out[5:0] <= 6'h31
      && rd_data_out[12:8] != 5'h0 && rd_data_out[12:8] <= 5'h12) else $error("bad date");
  AST_ALARM_HOLD:
    assert property (p_hold(alarm_wake_out)) else $error("alarm wake dropped");
  AST_TAMP_HOLD:
    assert property (p_hold(tamper_wake_out)) else $error("tamper wake dropped");
  AST_STAMP_HOLD:
    assert property (p_hold(stamp_wake_out)) else $error("stamp wake dropped");
  cover property ($rose(alarm_wake_out));
  cover property ($rose(tamper_wake_out));
  cover property ($rose(stamp_wake_out));
endmodule
bind rbk_rtc rbk_rtc_asserts u_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out), .alarm_wake_out(alarm_wake_out),
  .tamper_wake_out(tamper_wake_out), .stamp_wake_out(stamp_wake_out));

// ==== tb/rbk_rtc_tb.sv ====
// self-checking bench for the calendar timer
module rbk_rtc_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, rst = 1, wen = 0, ren = 0, go = 0, busy, rd_p = 0;
  logic tp1 = 0, tp2 = 1, tsp = 0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdat = 32'h0, rs = 32'h1b6e, rdo;
  logic [31:0] bk [5];
  logic [2:0] w = 3'h0, wk;
  logic [11:0] n = 12'h0;
  logic [4:0] tk;
  logic [31:0] expq [$];
  int failures = 0, checked = 0;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c};
  logic [31:0] rv [7] = '{0, 32'h2101, 0, 0, 32'h7f00ff, 0, 32'h80808000};
  logic [8:0] c12 = 9'h0e0;
  logic [31:0] t0 [9] = '{32'h235959, 32'h235959, 32'h235959, 32'h235959, 32'h235959,
    32'h115959, 32'h515959, 32'h525959, 32'h125959};
  logic [31:0] d0 [9] = '{32'h12228, 32'h42228, 32'h44229, 32'h12430, 32'h12131,
    32'h12101, 32'h12101, 32'h12101, 32'h12101};
  logic [31:0] t1 [9] = '{0, 0, 0, 0, 0, 32'h520000, 32'h120000, 32'h410000, 32'h130000};
  logic [31:0] d1 [9] = '{32'h14301, 32'h44229, 32'h46301, 32'h14501, 32'h14201,
    32'h12101, 32'h14102, 32'h12101, 32'h12101};
  always #2.5 mclk_in = ~mclk_in;
  rbk_rtc DUT (.mclk_in(mclk_in), .sys_rst_in(rst), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(wen), .rd_en_in(ren), .rd_data_out(rdo), .xtal_tick_in(tk[0]),
    .resonator_tick_in(tk[1]), .lprc_tick_in(tk[2]), .fast_external_oscillator_in(tk[3]),
    .ref_clk_in(tk[4]), .tamper_input_one_in(tp1), .tamper_input_two_in(tp2),
    .timestamp_input_in(tsp), .alarm_wake_out(wk[2]), .tamper_wake_out(wk[1]),
    .stamp_wake_out(wk[0]));
  rbk_clk_model u_clk (.mclk_in(mclk_in), .go_in(go), .which_in(w), .cnt_in(n),
    .busy_out(busy), .tick_out(tk));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdat <= d;
    wen <= 1'h1;
    @(posedge mclk_in);
    wen <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    addr <= a;
    ren <= 1'h1;
    expq.push_back(e);
    @(posedge mclk_in);
    ren <= 1'h0;
  endtask
  task automatic wake(input logic [2:0] e);
    #1 chk({29'h0, wk}, {29'h0, e});
  endtask
  task automatic tick(input logic [2:0] s, input logic [11:0] c);
    @(posedge mclk_in);
    w <= s;
    n <= c;
    go <= 1'h1;
    @(posedge mclk_in);
    go <= 1'h0;
    for (int i = 0; i < 4000 && (busy !== 1'h0 || i < 2); i++) @(posedge mclk_in);
    repeat (6) @(posedge mclk_in);
  endtask
  task automatic end_sim;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // read data stands in the cycle after the strobe; oldest note is compared
  always @(posedge mclk_in) begin
    if (rd_p) chk(rdo, expq.pop_front());
    rd_p <= ren;
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    failures++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    rst <= 1'h0;
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    wake(3'h0);
    for (int i = 0; i < 5; i++) begin
      rs = xs(rs);
      bk[i] = rs;
      wr(8'h50 + 8'(4 * i), rs);
      rd(8'h50 + 8'(4 * i), rs);
    end
    wr(8'h40, xs(rs));
    rd(8'h40, 32'h0);
    @(posedge mclk_in);
    rst <= 1'h1;
    repeat (6) @(posedge mclk_in);
    rst <= 1'h0;
    for (int i = 0; i < 5; i++) rd(8'h50 + 8'(4 * i), bk[i]);
    wr(8'h10, 32'h0);
    for (int i = 0; i < 9; i++) begin
      wr(8'h08, {31'h0, c12[i]});
      wr(8'h04, d0[i]);
      wr(8'h00, t0[i]);
      tick(3'h0, 12'h1);
      rd(8'h00, t1[i]);
      rd(8'h04, d1[i]);
    end
    for (int s = 0; s < 4; s++) begin
      wr(8'h08, 32'(s) << 9);
      wr(8'h00, 32'h0);
      tick(3'(s), 12'h1);
      rd(8'h00, 32'h1);
    end
    for (int m = 0; m < 2; m++) begin
      wr(8'h08, 32'h80 | (32'(m) << 8));
      wr(8'h00, 32'h0);
      tick(3'h4, m ? 12'h3c : 12'h32);
      rd(8'h00, 32'h1);
    end
    wr(8'h08, 32'h6);
    wr(8'h1c, 32'h80808005);
    wr(8'h00, 32'h4);
    wake(3'h0);
    tick(3'h0, 12'h1);
    wake(3'h4);
    rd(8'h0c, 32'h1);
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h0);
    wake(3'h0);
    for (int i = 0; i < 2; i++) begin
      wr(8'h08, 32'h868 | (32'h1000 << i) | (i ? 32'h0 : 32'h4000));
      wr(8'h00, 32'h101010);
      @(posedge mclk_in);
      if (i) tp2 <= 1'h0;
      else tp1 <= 1'h1;
      repeat (5) @(posedge mclk_in);
      wake(3'h3);
      rd(8'h0c, 32'h8 | (32'h2 << i));
      rd(8'h24, 32'h101010);
      @(posedge mclk_in);
      tp1 <= 1'h0;
      tp2 <= 1'h1;
      tsp <= 1'h1;
      repeat (5) @(posedge mclk_in);
      wake(3'h3);
      @(posedge mclk_in);
      tsp <= 1'h0;
      rd(8'h0c, 32'h18 | (32'h2 << i));
      wr(8'h0c, 32'h1f);
      rd(8'h0c, 32'h0);
      wake(3'h0);
    end
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h80000001);
    rd(8'h0c, 32'h20);
    tick(3'h0, 12'h4);
    rd(8'h0c, 32'h0);
    rd(8'h00, 32'h3);
    rd(8'h20, 32'h1);
    rs = xs(rs);
    wr(8'h18, rs & 32'h81ff);
    rd(8'h18, rs & 32'h81ff);
    repeat (4) @(posedge mclk_in);
    end_sim;
  end
endmodule
